// [inc/dpd_defs.svh]
// Purpose: Constants for the dual channel power-down control block
// Assumes: 200 MHz system clock
// Notes:   Timing figures are kept in their own unit; cycle counts derive from them
`ifndef DPD_DEFS_SVH
`define DPD_DEFS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define DPD_CLOCK_MHZ           200
`define DPD_IDLE_TIMEOUT_MS     60
`define DPD_IDLE_TIMEOUT_MIN_MS 50
`define DPD_IDLE_TIMEOUT_CYC    (`DPD_IDLE_TIMEOUT_MS * `DPD_CLOCK_MHZ * 1000)
`define DPD_IDLE_TIMER_W        24

// ----------------------------------------
// Synchroniser bit positions
// ----------------------------------------
`define DPD_SYN_PWM_A   0
`define DPD_SYN_PWM_B   1
`define DPD_SYN_PD_N    2
`define DPD_SYN_IDLE    3
`define DPD_SYN_REFERENCE_SOURCE_SELECT  4
`define DPD_SYN_W       5

// ----------------------------------------
// Pin levels and reset values
// ----------------------------------------
`define DPD_IDLE_SAMPLE_HOLD 1'b1
`define DPD_REF_EXTERNAL     1'b1
// Idle select presets to sample/hold so power-up stays down until the real pin level is seen
`define DPD_RST_SYNC         5'h0C
`define DPD_RST_FULL_PD      1'b1
`define DPD_RST_CHAN_HIZ     2'h3

`endif

// [inc/dpd_pkg.sv]
// Purpose: Types shared by the power-down control block
// Assumes: dpd_defs.svh holds all numbers
// Notes:   Two channels, fixed by the device
package dpd_pkg;

  typedef enum logic [2:0] {
    DPD_CH_ACTIVE,
    DPD_CH_ZERO,
    DPD_CH_FULL,
    DPD_CH_HIZ,
    DPD_CH_HOLD
  } dpd_chan_mode_t;

  typedef struct packed {
    logic [4:0]            sync1;
    logic [4:0]            sync2;
    logic [1:0]            pwm_prev;
    logic                  full_pd;
    logic [1:0]            code_valid;
    dpd_chan_mode_t [1:0]  mode;
    logic [1:0]            chan_enable;
    logic [1:0]            chan_hiz;
    logic [1:0]            force_zero;
    logic [1:0]            force_full;
    logic [1:0]            code_update;
    logic                  int_ref_on;
    logic                  scale_pin_hiz;
    logic                  ext_ref_sel;
    logic                  bias_on;
  } dpd_ctrl_state_t;

endpackage

// [logic/dpd_idle_timer.sv]
// Purpose: Per-channel idle timeout and rising-edge pair detector
// Assumes: rise is a one-cycle pulse from logic on the same clock
// Notes:   A pair of edges closer than the timeout yields one update pulse
`timescale 1ns/1ps
`include "dpd_defs.svh"

module dpd_idle_timer #(
  parameter int                         TIMER_W = `DPD_IDLE_TIMER_W,
  parameter logic [`DPD_IDLE_TIMER_W-1:0] LIMIT = `DPD_IDLE_TIMER_W'(`DPD_IDLE_TIMEOUT_CYC)
) (
  // Clock and reset
  input  wire logic  clock,
  input  wire logic  reset_n,
  // Events
  input  wire logic  rise,
  input  wire logic  clear,
  // Status
  output logic       expired_q,
  output logic       update_q
);

  typedef struct packed {
    logic [TIMER_W-1:0] count;
    logic               armed;
    logic               expired;
    logic               update;
  } dpd_timer_state_t;

  dpd_timer_state_t st_q;
  dpd_timer_state_t st_d;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d        = st_q;
    st_d.update = 1'b0;
    if (clear) begin
      st_d.count   = '0;
      st_d.armed   = 1'b0;
      st_d.expired = 1'b0;
    end else if (rise) begin
      // An edge after expiry only re-arms: the pair was too far apart
      st_d.update  = st_q.armed && !st_q.expired;
      st_d.armed   = 1'b1;
      st_d.count   = '0;
      st_d.expired = 1'b0;
    end else if (!st_q.expired) begin
      if (st_q.count == LIMIT - TIMER_W'(1)) begin
        st_d.expired = 1'b1;
      end else begin
        st_d.count = st_q.count + TIMER_W'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign expired_q = st_q.expired;
  assign update_q  = st_q.update;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_timer_clear: assert property (@(posedge clock) disable iff (!reset_n)
    clear |=> (st_q.count == '0) && !st_q.armed && !update_q)
    else $error("idle timer not cleared while powered down");

  a_timer_expire: assert property (@(posedge clock) disable iff (!reset_n)
    (st_q.count == LIMIT - TIMER_W'(1)) && !rise && !clear |=> expired_q)
    else $error("idle timeout did not expire on time");

endmodule

// [logic/dpd_power_ctrl.sv]
// Purpose: Power state and reference mode control for two PWM driven output channels
// Assumes: All control pins are asynchronous and pass two flip-flops first
// Notes:   Outputs are registered copies of the state word
`timescale 1ns/1ps
`include "dpd_defs.svh"

module dpd_power_ctrl
  import dpd_pkg::*;
#(
  parameter logic [`DPD_IDLE_TIMER_W-1:0] IDLE_TIMEOUT_CYCLES = `DPD_IDLE_TIMER_W'(`DPD_IDLE_TIMEOUT_CYC)
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Pins from the outside
  input  wire logic [1:0]  pwm_in,
  input  wire logic        power_down_n,
  input  wire logic        idle_behaviour_select,
  input  wire logic        reference_source_select,
  // Channel control
  output logic [1:0]       analog_output_channel_enable_q,
  output logic [1:0]       analog_output_channel_hiz_q,
  output logic [1:0]       analog_output_channel_zero_q,
  output logic [1:0]       analog_output_channel_full_q,
  output logic [1:0]       code_update_q,
  // Reference and bias control
  output logic             internal_reference_on_q,
  output logic             scale_pin_hiz_q,
  output logic             external_reference_sel_q,
  output logic             bias_on_q
);

  dpd_ctrl_state_t st_q;
  dpd_ctrl_state_t st_d;

  logic [1:0] expired;
  logic [1:0] update;
  logic [1:0] rise;
  logic       pd_active;
  logic       sample_hold;
  logic       ref_external;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic is_down(input dpd_chan_mode_t m);
    is_down = (m == DPD_CH_HIZ);
  endfunction

  // ----------------------------------------
  // Synchronised pin views
  // ----------------------------------------
  // Only the second stage is read; the first stage feeds nothing else
  assign pd_active    = !st_q.sync2[`DPD_SYN_PD_N];
  assign sample_hold  = (st_q.sync2[`DPD_SYN_IDLE] == `DPD_IDLE_SAMPLE_HOLD);
  assign ref_external = (st_q.sync2[`DPD_SYN_REFERENCE_SOURCE_SELECT] == `DPD_REF_EXTERNAL);
  assign rise         = st_q.sync2[1:0] & ~st_q.pwm_prev;

  // ----------------------------------------
  // Per-channel idle timers
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      dpd_idle_timer #(
        .TIMER_W (`DPD_IDLE_TIMER_W),
        .LIMIT   (IDLE_TIMEOUT_CYCLES)
      ) u_timer (
        .clock     (clock),
        .reset_n   (reset_n),
        .rise      (rise[g]),
        .clear     (pd_active),
        .expired_q (expired[g]),
        .update_q  (update[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d          = st_q;
    st_d.sync1    = {reference_source_select, idle_behaviour_select, power_down_n, pwm_in};
    st_d.sync2    = st_q.sync1;
    st_d.pwm_prev = st_q.sync2[1:0];

    // Full power-down latch; only sample/hold keeps it past the pin release
    if (pd_active) begin
      st_d.full_pd = sample_hold;
    end else if (!sample_hold) begin
      st_d.full_pd = 1'b0;
    end else if (|rise) begin
      st_d.full_pd = 1'b0;
    end

    for (int i = 0; i < 2; i++) begin
      if (pd_active) begin
        st_d.mode[i] = DPD_CH_HIZ;
      end else if (sample_hold) begin
        if (is_down(st_q.mode[i]) || st_q.full_pd) begin
          // Woken channel keeps high impedance until a real code exists
          st_d.mode[i] = update[i] ? DPD_CH_ACTIVE : DPD_CH_HIZ;
        end else if (expired[i] && !st_q.sync2[i]) begin
          st_d.mode[i] = DPD_CH_HIZ;
        end else if (expired[i]) begin
          st_d.mode[i] = DPD_CH_HOLD;
        end else begin
          st_d.mode[i] = DPD_CH_ACTIVE;
        end
      end else begin
        if (expired[i]) begin
          st_d.mode[i] = st_q.sync2[i] ? DPD_CH_FULL : DPD_CH_ZERO;
        end else if (!st_q.code_valid[i] && !update[i]) begin
          st_d.mode[i] = DPD_CH_ZERO;
        end else begin
          st_d.mode[i] = DPD_CH_ACTIVE;
        end
      end

      if (update[i] && !pd_active) begin
        st_d.code_valid[i] = 1'b1;
      end
      st_d.code_update[i] = update[i] && !pd_active;
      st_d.chan_enable[i] = !is_down(st_d.mode[i]);
      st_d.chan_hiz[i]    = is_down(st_d.mode[i]);
      st_d.force_zero[i]  = (st_d.mode[i] == DPD_CH_ZERO);
      st_d.force_full[i]  = (st_d.mode[i] == DPD_CH_FULL);
    end

    // Bias and reference follow the channel outcome of this same update
    st_d.bias_on       = !pd_active && !st_d.full_pd
                         && !(is_down(st_d.mode[0]) && is_down(st_d.mode[1]));
    st_d.int_ref_on    = st_d.bias_on && !ref_external;
    st_d.ext_ref_sel   = ref_external;
    st_d.scale_pin_hiz = !st_d.int_ref_on;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q               <= '0;
      st_q.sync1         <= `DPD_RST_SYNC;
      st_q.sync2         <= `DPD_RST_SYNC;
      st_q.full_pd       <= `DPD_RST_FULL_PD;
      st_q.mode          <= '{DPD_CH_HIZ, DPD_CH_HIZ};
      st_q.chan_hiz      <= `DPD_RST_CHAN_HIZ;
      st_q.scale_pin_hiz <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign analog_output_channel_enable_q = st_q.chan_enable;
  assign analog_output_channel_hiz_q    = st_q.chan_hiz;
  assign analog_output_channel_zero_q   = st_q.force_zero;
  assign analog_output_channel_full_q   = st_q.force_full;
  assign code_update_q                  = st_q.code_update;
  assign internal_reference_on_q        = st_q.int_ref_on;
  assign scale_pin_hiz_q                = st_q.scale_pin_hiz;
  assign external_reference_sel_q       = st_q.ext_ref_sel;
  assign bias_on_q                      = st_q.bias_on;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  a_ref_ext_off: assert property (
    ref_external |=> !internal_reference_on_q && external_reference_sel_q)
    else $error("integrated reference on in external mode");

  a_ref_int_on: assert property (
    !ref_external && !pd_active && st_q.chan_enable[0] && !st_q.full_pd
    ##1 st_q.chan_enable[0] && !st_q.full_pd |-> internal_reference_on_q)
    else $error("integrated reference off with a live channel");

  a_ref_both_off: assert property (
    analog_output_channel_hiz_q == 2'h3 |-> !internal_reference_on_q && !bias_on_q)
    else $error("reference on with both channels down");

  a_pd_all_down: assert property (
    pd_active |=> analog_output_channel_hiz_q == 2'h3 && !internal_reference_on_q && !bias_on_q)
    else $error("power-down pin did not stop channels and reference");

  a_ref_pin_hiz: assert property (
    !internal_reference_on_q |-> scale_pin_hiz_q)
    else $error("scale pin driven with reference off");

  a_transp_wake: assert property (
    !sample_hold && !pd_active && $past(pd_active) |=> analog_output_channel_hiz_q == 2'h0 && bias_on_q)
    else $error("transparent mode did not resume after power-down");

  a_shold_stay: assert property (
    sample_hold && !pd_active && st_q.full_pd && rise == 2'h0 |=> !bias_on_q && st_q.full_pd)
    else $error("sample/hold woke without a rising edge");

  a_idle_low_down: assert property (
    sample_hold && !pd_active && expired[0] && !st_q.sync2[0] |=> analog_output_channel_hiz_q[0])
    else $error("idle low channel not powered down");

  a_hiz_until_upd: assert property (
    sample_hold && !pd_active && analog_output_channel_hiz_q[1] && !update[1] |=> analog_output_channel_hiz_q[1])
    else $error("channel left high impedance without an update");

  a_transp_idle: assert property (
    !sample_hold && !pd_active && expired[0] ##0 (st_q.sync2[0] == 1'b1) |=> analog_output_channel_full_q[0])
    else $error("idle high transparent channel not at full-scale");

  a_update_pulse: assert property (
    update[1] && !pd_active |=> code_update_q[1] ##1 !code_update_q[1])
    else $error("code update not a single pulse");

endmodule

// [verif/dpd_pwm_src.sv]
// Purpose: PWM source model for the two channel inputs
// Assumes: Driven by the bench through its tasks
// Notes:   Lines change only just after a rising clock edge
`timescale 1ns/1ps

module dpd_pwm_src (
  // Clock
  input  wire logic  clock,
  // PWM lines
  output logic [1:0] pwm_in
);
  initial pwm_in = 2'h0;

  // ----------------------------------------
  // Edge tasks
  // ----------------------------------------
  // High then low, each long enough to be sampled twice
  task automatic rise(input int ch, input int hi, input int lo);
    @(posedge clock);
    pwm_in[ch] <= 1'b1;
    repeat (hi) @(posedge clock);
    pwm_in[ch] <= 1'b0;
    repeat (lo) @(posedge clock);
  endtask

  // Two edges well inside the timeout, enough to wake a channel
  task automatic pair(input int ch);
    rise(ch, 3, 3);
    rise(ch, 3, 3);
  endtask

  task automatic level(input int ch, input logic v);
    @(posedge clock);
    pwm_in[ch] <= v;
  endtask
endmodule

// [verif/tb.sv]
// Purpose: Self-checking bench for the power-down control block
// Assumes: Timeout shortened to 40 cycles
// Notes:   Levels are checked several cycles after a pin change
`timescale 1ns/1ps

module tb;
  localparam int TMO = 40;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic       clock    = 1'b0;
  logic       reset_n  = 1'b0;
  logic       pd_n     = 1'b1;
  logic       idle_sel = 1'b1;
  logic       ref_sel  = 1'b0;
  logic [1:0] pwm;
  logic [1:0] en;
  logic [1:0] hiz;
  logic [1:0] zero;
  logic [1:0] full;
  logic [1:0] upd;
  logic       iref;
  logic       shiz;
  logic       exts;
  logic       bias;
  int         upd_cnt [2];
  int         miscompares = 0;
  int         checks_done = 0;

  always #2.5 clock = ~clock;

  dpd_pwm_src src (
    .clock  (clock),
    .pwm_in (pwm)
  );

  dpd_power_ctrl #(.IDLE_TIMEOUT_CYCLES(24'h000028)) dut (
    .clock                          (clock),
    .reset_n                        (reset_n),
    .pwm_in                         (pwm),
    .power_down_n                   (pd_n),
    .idle_behaviour_select          (idle_sel),
    .reference_source_select        (ref_sel),
    .analog_output_channel_enable_q (en),
    .analog_output_channel_hiz_q    (hiz),
    .analog_output_channel_zero_q   (zero),
    .analog_output_channel_full_q   (full),
    .code_update_q                  (upd),
    .internal_reference_on_q        (iref),
    .scale_pin_hiz_q                (shiz),
    .external_reference_sel_q       (exts),
    .bias_on_q                      (bias)
  );

  // Counting pulses avoids looking for a one-cycle flag at a guessed edge
  always @(posedge clock) begin
    for (int i = 0; i < 2; i++) begin
      if (upd[i] === 1'b1) upd_cnt[i]++;
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] status();
    return {1'b0, hiz, en, iref, shiz, bias};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_sh_reset();
    cyc(8);
    chk("status", 8'h62, status());
    chk("ext sel", 8'h00, {7'h00, exts});
  endtask

  task automatic t_sh_wake();
    src.pair(0);
    cyc(4);
    chk("updates ch0", 8'h01, 8'(upd_cnt[0]));
    chk("status", 8'h4D, status());
  endtask

  task automatic t_ext_ref();
    @(posedge clock);
    ref_sel <= 1'b1;
    cyc(5);
    chk("iref shiz ext", 8'h03, {5'h00, iref, shiz, exts});
    ref_sel <= 1'b0;
    cyc(5);
    chk("iref shiz ext", 8'h04, {5'h00, iref, shiz, exts});
  endtask

  task automatic t_sh_idle();
    cyc(TMO + 8);
    chk("status", 8'h62, status());
    src.rise(1, 3, 3);
    cyc(TMO + 10);
    src.rise(1, 3, 3);
    cyc(4);
    chk("updates ch1", 8'h00, 8'(upd_cnt[1]));
    src.rise(1, 3, 3);
    cyc(4);
    chk("updates ch1", 8'h01, 8'(upd_cnt[1]));
    chk("status", 8'h35, status());
    src.level(1, 1'b1);
    cyc(TMO + 10);
    chk("status", 8'h35, status());
    src.level(1, 1'b0);
  endtask

  task automatic t_power_down();
    @(posedge clock);
    pd_n <= 1'b0;
    cyc(5);
    chk("status", 8'h62, status());
    src.pair(0);
    cyc(4);
    chk("updates ch0", 8'h01, 8'(upd_cnt[0]));
    pd_n <= 1'b1;
    cyc(8);
    chk("status", 8'h62, status());
    src.pair(1);
    cyc(4);
    chk("updates ch1", 8'h03, 8'(upd_cnt[1]));
    chk("status", 8'h35, status());
  endtask

  task automatic t_transparent();
    @(posedge clock);
    pd_n     <= 1'b0;
    idle_sel <= 1'b0;
    cyc(4);
    pd_n <= 1'b1;
    cyc(5);
    chk("hiz iref shiz bias", 8'h05, {3'h0, hiz, iref, shiz, bias});
    cyc(TMO + 8);
    chk("zero full", 8'h0C, {4'h0, zero, full});
    src.level(0, 1'b1);
    cyc(TMO + 8);
    chk("zero full", 8'h09, {4'h0, zero, full});
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    upd_cnt[0] = 0;
    upd_cnt[1] = 0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    t_sh_reset();
    t_sh_wake();
    t_ext_ref();
    t_sh_idle();
    t_power_down();
    t_transparent();
    report_and_stop();
  end

  // Whole run is well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    report_and_stop();
  end
endmodule
